// [dv/lbp_host_model.sv]
// host bus controller: issues one register cycle per call, one strobe
// cycle long, then lets the address bus float to the inverse value
module lbp_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic [7:0]  i_reg_rdata,
    input  wire logic        i_reg_rvalid,
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic [31:0]      o_reg_addr,
    output logic [7:0]       o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = 32'h00000000;
        o_reg_wdata = 8'h00;
    end

    // rdata is taken one edge after the strobe, where it stands
    task automatic cyc(input logic wr, input logic [31:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge i_sys_clk);
        o_reg_wr    <= wr;
        o_reg_rd    <= !wr;
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        @(posedge i_sys_clk);
        o_reg_wr    <= 1'b0;
        o_reg_rd    <= 1'b0;
        o_reg_addr  <= ~a;
        o_reg_wdata <= ~d;
        #1;
        q = i_reg_rvalid ? i_reg_rdata : 8'hEE; // missing answer never matches
    endtask
endmodule

// [dv/tb.sv]
`include "lbp_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus signals
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, host = 1'b1, wr, rd, req = 1'b0, clr = 1'b0;
    logic ard = 1'b0, boot_n = 1'b1, main_n = 1'b1, go, rej, stat, rv, arv;
    logic [31:0] addr;
    logic [7:0]  wd, rdat, adat = 8'h00, ardat;
    logic [2:0]  blk = 3'h0, ablk = 3'h0;
    logic [4:0]  gpi = 5'h00;
    lbp_pkg::lbp_op_t kind = lbp_pkg::LBP_OP_PROGRAM;
    logic exp_stat = 1'b0;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    localparam logic [31:0] LA [7] = '{`LBP_ADDR_BLK0_LOCK, `LBP_ADDR_BLK1_LOCK,
        `LBP_ADDR_BLK2_LOCK, `LBP_ADDR_BLK3_LOCK, `LBP_ADDR_BLK4_LOCK,
        `LBP_ADDR_BLK5_LOCK, `LBP_ADDR_BLK6_LOCK};

    always #4 clk = ~clk;

    lbp_host_model u_lbp_host_model (.i_sys_clk(clk), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
        .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wd));

    lbp_block_protect u_lbp_block_protect (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_host_mode(host), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wd), .i_op_req(req), .i_op_kind(kind), .i_op_block(blk),
        .i_clear_status(clr), .i_arr_rd(ard), .i_arr_block(ablk), .i_arr_data(adat),
        .i_boot_block_lock_pin_n(boot_n), .i_main_protect_pin_n(main_n),
        .i_general_input_pins(gpi), .o_reg_rdata(rdat), .o_reg_rvalid(rv),
        .o_op_go(go), .o_op_reject(rej), .o_prot_status(stat), .o_arr_rdata(ardat),
        .o_arr_rvalid(arv));

    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // synchronisers need several edges, so hold the full 20 cycles
    task automatic reset();
        @(posedge clk);
        rst_n <= 1'b0;
        exp_stat = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_lbp_host_model.cyc(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_lbp_host_model.cyc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    // answer lands exactly one edge after the request
    task automatic op(input lbp_pkg::lbp_op_t k, input logic [2:0] b, input logic ok);
        @(posedge clk);
        req <= 1'b1;
        kind <= k;
        blk <= b;
        @(posedge clk);
        req <= 1'b0;
        #1;
        exp_stat = exp_stat | !ok;
        chk(8'({go, rej, stat}), 8'({ok, !ok, exp_stat}));
    endtask

    task automatic arr(input logic [2:0] b, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk);
        ard <= 1'b1;
        ablk <= b;
        adat <= d;
        @(posedge clk);
        ard <= 1'b0;
        adat <= ~d;
        #1;
        chk(ardat, e);
        chk(8'(arv), 8'h01);
    endtask

    task automatic pins(input logic b, input logic m);
        @(posedge clk);
        boot_n <= b;
        main_n <= m;
        repeat (3) @(posedge clk);
    endtask

    // hang guard, well above the roughly 150 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset();
        for (int i = 0; i < 7; i++) rd_chk(LA[i], 8'h01);
        for (int i = 0; i < 7; i++) op(lbp_pkg::LBP_OP_PROGRAM, 3'(i), 1'b0);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1 chk(8'(stat), 8'h00);
        exp_stat = 1'b0;
        wr_reg(LA[2], 8'h00);
        op(lbp_pkg::LBP_OP_ERASE, 3'h2, 1'b1);
        pins(1'b1, 1'b0);
        op(lbp_pkg::LBP_OP_ERASE, 3'h2, 1'b0);
        pins(1'b1, 1'b1);
        wr_reg(LA[6], 8'h00);
        op(lbp_pkg::LBP_OP_PROGRAM, 3'h6, 1'b1);
        pins(1'b0, 1'b1);
        op(lbp_pkg::LBP_OP_PROGRAM, 3'h6, 1'b0);
        op(lbp_pkg::LBP_OP_PROGRAM, 3'h2, 1'b1);
        pins(1'b1, 1'b1);
        wr_reg(LA[4], 8'h04);
        arr(3'h4, 8'hA5, 8'h00);
        arr(3'h3, 8'hA5, 8'hA5);
        wr_reg(LA[5], 8'h02);
        wr_reg(LA[5], 8'h05);
        rd_chk(LA[5], 8'h02);
        op(lbp_pkg::LBP_OP_ERASE, 3'h5, 1'b1);
        wr_reg(LA[0], 8'hF8);
        rd_chk(LA[0], 8'h00);
        @(posedge clk);
        gpi <= 5'h15;
        repeat (3) @(posedge clk);
        rd_chk(`LBP_ADDR_INPUTS, 8'h15);
        wr_reg(`LBP_ADDR_INPUTS, 8'hFF);
        rd_chk(`LBP_ADDR_INPUTS, 8'h15);
        rd_chk(LA[1], 8'h01);
        @(posedge clk);
        gpi <= 5'h0A;
        repeat (3) @(posedge clk);
        rd_chk(`LBP_ADDR_INPUTS, 8'h0A);
        @(posedge clk);
        host <= 1'b0;
        rd_chk(LA[1], 8'h00);
        wr_reg(LA[1], 8'h00);
        @(posedge clk);
        host <= 1'b1;
        rd_chk(LA[1], 8'h01);
        reset();
        rd_chk(LA[5], 8'h01);
        rd_chk(LA[4], 8'h01);
        chk(8'(stat), 8'h00);
        test_done();
    end
endmodule

// [hw/lbp_block_protect.sv]
`include "lbp_defs.svh"

module lbp_block_protect #(
    parameter int NUM_BLOCKS = `LBP_NUM_BLOCKS,
    parameter int NUM_INPUTS = `LBP_NUM_INPUTS
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_host_mode,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [31:0]           i_reg_addr,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic                  i_op_req,
    input  wire lbp_pkg::lbp_op_t      i_op_kind,
    input  wire logic [2:0]            i_op_block,
    input  wire logic                  i_clear_status,
    input  wire logic                  i_arr_rd,
    input  wire logic [2:0]            i_arr_block,
    input  wire logic [7:0]            i_arr_data,
    input  wire logic                  i_boot_block_lock_pin_n,
    input  wire logic                  i_main_protect_pin_n,
    input  wire logic [NUM_INPUTS-1:0] i_general_input_pins,
    output logic [7:0]                 o_reg_rdata,
    output logic                       o_reg_rvalid,
    output logic                       o_op_go,
    output logic                       o_op_reject,
    output logic                       o_prot_status,
    output logic [7:0]                 o_arr_rdata,
    output logic                       o_arr_rvalid
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] gpi_m;
    logic [NUM_INPUTS-1:0] gpi_s;
    logic [1:0]            pin_m;
    logic [1:0]            pin_s;

    // first stage read only by the second
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            gpi_m <= '0;
            gpi_s <= '0;
            pin_m <= 2'h3;
            pin_s <= 2'h3;
        end else begin
            gpi_m <= i_general_input_pins;
            gpi_s <= gpi_m;
            pin_m <= {i_main_protect_pin_n, i_boot_block_lock_pin_n};
            pin_s <= pin_m;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [31:0]       blk_addr [NUM_BLOCKS];
    logic [NUM_BLOCKS-1:0] blk_hit;
    logic              gpi_hit;

    assign blk_addr[0] = `LBP_ADDR_BLK0_LOCK;
    assign blk_addr[1] = `LBP_ADDR_BLK1_LOCK;
    assign blk_addr[2] = `LBP_ADDR_BLK2_LOCK;
    assign blk_addr[3] = `LBP_ADDR_BLK3_LOCK;
    assign blk_addr[4] = `LBP_ADDR_BLK4_LOCK;
    assign blk_addr[5] = `LBP_ADDR_BLK5_LOCK;
    assign blk_addr[6] = `LBP_ADDR_BLK6_LOCK;
    assign gpi_hit     = i_host_mode && (i_reg_addr == `LBP_ADDR_INPUTS);

    // ------------------------------------------------------------
    // lock registers
    // ------------------------------------------------------------
    lbp_pkg::lbp_lock_t lock [NUM_BLOCKS];

    // one register per block; the input register has no write path
    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
        assign blk_hit[b] = i_host_mode && (i_reg_addr == blk_addr[b]);
        lbp_lock_reg u_lock (
            .i_sys_clk (i_sys_clk),
            .i_rst_n   (i_rst_n),
            .i_wr      (i_reg_wr && blk_hit[b]),
            .i_wdata   (i_reg_wdata),
            .o_lock    (lock[b])
        );
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    // unmapped or other-interface reads return zero
    always_comb begin
        next_rdata = 8'h00;
        for (int b = 0; b < NUM_BLOCKS; b++) begin
            if (blk_hit[b]) begin
                next_rdata = {5'h00, lock[b]};
            end
        end
        if (gpi_hit) begin
            next_rdata = {{(8-NUM_INPUTS){1'b0}}, gpi_s};
        end
    end

    // read answers one cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rdata  <= i_reg_rd ? next_rdata : 8'h00;
            o_reg_rvalid <= i_reg_rd;
        end
    end

    // ------------------------------------------------------------
    // write protection of program and erase
    // ------------------------------------------------------------
    logic op_blk_ok;
    logic op_prot;

    assign op_blk_ok = (32'(i_op_block) < NUM_BLOCKS);
    // pins only bite in host mode; out-of-range block counts as protected
    always_comb begin
        op_prot = 1'b1;
        if (op_blk_ok) begin
            op_prot = lock[i_op_block][`LBP_BIT_MODIFY_LOCK];
            if (i_host_mode && 32'(i_op_block) == `LBP_BOOT_BLOCK &&
                !pin_s[0]) begin
                op_prot = 1'b1;
            end
            if (i_host_mode && 32'(i_op_block) < `LBP_BOOT_BLOCK &&
                !pin_s[1]) begin
                op_prot = 1'b1;
            end
        end
    end

    // go or reject answered one cycle after the request
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_op_go     <= 1'b0;
            o_op_reject <= 1'b0;
        end else begin
            o_op_go     <= i_op_req && !op_prot;
            o_op_reject <= i_op_req && op_prot;
        end
    end

    // sticky error; a new rejection beats a simultaneous clear
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_prot_status <= 1'b0;
        end else if (i_op_req && op_prot) begin
            o_prot_status <= 1'b1;
        end else if (i_clear_status) begin
            o_prot_status <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // array read masking
    // ------------------------------------------------------------
    logic rd_locked;

    assign rd_locked = (32'(i_arr_block) < NUM_BLOCKS) &&
                       lock[i_arr_block][`LBP_BIT_READ_LOCK];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_arr_rdata  <= 8'h00;
            o_arr_rvalid <= 1'b0;
        end else begin
            o_arr_rdata  <= (i_arr_rd && !rd_locked) ? i_arr_data : 8'h00;
            o_arr_rvalid <= i_arr_rd;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_RESET_LOCK: assert property (@(posedge i_sys_clk)
        $fell(i_rst_n) |=> (lock[0] == 3'h1 && lock[6] == 3'h1))
        else $error("lock not 01h after reset");

    AST_FREEZE_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        lock[5][`LBP_BIT_FREEZE] |=> $stable(lock[5]))
        else $error("frozen lock register changed");

    AST_MODIFY_REJECT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_op_req && i_op_block == 3'h2 && lock[2][0]) |=> (o_op_reject && !o_op_go))
        else $error("locked block not rejected");

    AST_UNLOCKED_GO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_op_req && i_op_block == 3'h2 && !lock[2][0] && pin_s[1]) |=> o_op_go)
        else $error("unlocked block not executed");

    AST_BOOT_PIN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_op_req && i_host_mode && i_op_block == 3'h6 && !pin_s[0]) |=> o_op_reject)
        else $error("boot block pin ignored");

    AST_MAIN_PIN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_op_req && i_host_mode && i_op_block < 3'h6 && !pin_s[1]) |=> o_op_reject)
        else $error("main protect pin ignored");

    AST_READ_LOCK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_arr_rd && i_arr_block == 3'h4 && lock[4][2]) |=> (o_arr_rdata == 8'h00))
        else $error("read-locked block returned data");

    AST_STATUS_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_prot_status && !i_clear_status) |=> o_prot_status)
        else $error("protection status dropped");

    AST_GPI_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reg_rd && gpi_hit) |=> (o_reg_rdata == {3'h0, $past(gpi_s)}))
        else $error("input register read wrong");

    AST_OFF_MODE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reg_rd && !i_host_mode) |=> (o_reg_rdata == 8'h00))
        else $error("register visible outside host mode");

    // handshake shape: every strobe answered once, nothing without a strobe
    AST_RD_ANSWER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_reg_rd |=> o_reg_rvalid)
        else $error("register read not answered");

    AST_RD_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_reg_rd |=> (!o_reg_rvalid && o_reg_rdata == 8'h00))
        else $error("register read data outside a read");

    AST_RSVD_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_reg_rvalid |-> (o_reg_rdata[7:5] == 3'h0))
        else $error("reserved register bits not zero");

    AST_LOCK_READBACK: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reg_rd && blk_hit[5]) |=> (o_reg_rdata == {5'h00, $past(lock[5])}))
        else $error("lock register read back wrong");

    AST_LOCK_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reg_wr && blk_hit[2] && !lock[2][`LBP_BIT_FREEZE]) |=>
            (lock[2] == $past(i_reg_wdata[2:0])))
        else $error("unfrozen lock register not written");

    AST_OP_ANSWER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_op_req |=> (o_op_go != o_op_reject))
        else $error("request not answered exactly once");

    AST_OP_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_op_req |=> (!o_op_go && !o_op_reject))
        else $error("go or reject without request");

    AST_STATUS_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_op_req && op_prot) |=> o_prot_status)
        else $error("rejection did not set status");

    AST_STATUS_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clear_status && !(i_op_req && op_prot)) |=> !o_prot_status)
        else $error("clear-status ignored");

    AST_ARR_PASS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_arr_rd && i_arr_block == 3'h3 && !lock[3][`LBP_BIT_READ_LOCK]) |=>
            (o_arr_rdata == $past(i_arr_data)))
        else $error("unlocked block read masked");

    AST_ARR_ANSWER: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_arr_rd |=> o_arr_rvalid)
        else $error("array read not answered");

    AST_ARR_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_arr_rd |=> (!o_arr_rvalid && o_arr_rdata == 8'h00))
        else $error("array data outside a read");

    AST_GPI_NO_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reg_wr && gpi_hit) |=> ($stable(lock[0]) && $stable(lock[1])))
        else $error("input register write changed a lock");

    AST_OFF_MODE_WR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_reg_wr && !i_host_mode) |=> $stable(lock[1]))
        else $error("lock written outside host mode");

    AST_RESET_READ_OPEN: assert property (@(posedge i_sys_clk)
        $fell(i_rst_n) |=> (lock[4] == 3'h1 && lock[5] == 3'h1))
        else $error("read lock or freeze survived reset");

    // every block, not only the one the bench freezes
    for (genvar f = 0; f < NUM_BLOCKS; f++) begin : g_frz_chk
        AST_FREEZE_ALL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
            lock[f][`LBP_BIT_FREEZE] |=> $stable(lock[f]))
            else $error("frozen lock register changed");
    end
endmodule

// [hw/lbp_defs.svh]
`ifndef LBP_DEFS_SVH
`define LBP_DEFS_SVH

// ------------------------------------------------------------
// register addresses (boot memory map, identity inputs low)
// ------------------------------------------------------------
`define LBP_ADDR_BLK0_LOCK  32'hFF7C0002
`define LBP_ADDR_BLK1_LOCK  32'hFF7D0002
`define LBP_ADDR_BLK2_LOCK  32'hFF7E0002
`define LBP_ADDR_BLK3_LOCK  32'hFF7F0002
`define LBP_ADDR_BLK4_LOCK  32'hFF7F8002
`define LBP_ADDR_BLK5_LOCK  32'hFF7FA002
`define LBP_ADDR_BLK6_LOCK  32'hFF7FC002
`define LBP_ADDR_INPUTS     32'hFF7C0100

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define LBP_BIT_MODIFY_LOCK 0
`define LBP_BIT_FREEZE      1
`define LBP_BIT_READ_LOCK   2
`define LBP_LOCK_RESET      8'h01
`define LBP_STAT_PROT_BIT   1
`define LBP_BOOT_BLOCK      6
`define LBP_NUM_BLOCKS      7
`define LBP_NUM_INPUTS      5

`endif

// [hw/lbp_lock_reg.sv]
`include "lbp_defs.svh"

// one block's lock register: modify lock, freeze, read lock
module lbp_lock_reg (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_wr,
    input  wire logic [7:0]       i_wdata,
    output lbp_pkg::lbp_lock_t    o_lock
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // freeze only falls at reset, so software cannot unlock once frozen
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_lock <= lbp_pkg::lbp_lock_t'(`LBP_LOCK_RESET);
        end else if (i_wr && !o_lock[`LBP_BIT_FREEZE]) begin
            o_lock <= i_wdata[2:0];
        end
    end
endmodule

// [hw/lbp_pkg.sv]
package lbp_pkg;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LBP_OP_PROGRAM = 2'h1,
        LBP_OP_ERASE   = 2'h2
    } lbp_op_t;
    typedef logic [2:0] lbp_lock_t;
endpackage
